// File: sac_pkg.sv
// Shared constants and types of the converter control block.
// Assumes one 125 MHz peripheral clock and an APB master.
package sac_pkg;
    // ==========================================
    // Clocking
    // ==========================================
    localparam int PCLK_HZ = 125_000_000;
    localparam int CONV_MAX_HZ = 18_000_000;
    localparam int CONV_MIN_HZ = 1_800_000;
    // Least divide ratio that keeps the converter clock at or under its top rate
    localparam int CONV_DIV = (PCLK_HZ + CONV_MAX_HZ - 1) / CONV_MAX_HZ;
    localparam logic [2:0] DIV_LAST = 3'(CONV_DIV - 1);
    // ==========================================
    // Sizes
    // ==========================================
    localparam int NCH = 16;
    localparam int CODE_W = 12;
    localparam int RES_W = 16;
    localparam int ACQ_W = 10;
    localparam logic [3:0] TOP_BIT = 4'hb;
    localparam logic [ACQ_W-1:0] ACQ_MIN = 10'h004;
    localparam logic [CODE_W-1:0] CODE_MID = 12'h800;
    // ==========================================
    // Register map (byte addresses)
    // ==========================================
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_SAMPLE = 12'h004;
    localparam logic [11:0] OFS_TLOW = 12'h008;
    localparam logic [11:0] OFS_THIGH = 12'h00c;
    localparam logic [11:0] OFS_STATUS = 12'h010;
    localparam logic [11:0] OFS_CFG_BASE = 12'h040;
    localparam logic [11:0] OFS_RES_BASE = 12'h080;
    localparam logic [11:0] OFS_WIN_MASK = 12'hfc3;
    // Control register fields
    localparam int CTRL_EN = 0;
    localparam int CTRL_CONT = 1;
    localparam int CTRL_FW = 2;
    localparam int CTRL_START = 3;
    localparam int CTRL_NEG = 4;
    localparam int CTRL_FWCH = 8;
    // Sample control fields
    localparam int SMP_LEFT = 0;
    localparam int SMP_DSIGN = 1;
    localparam int SMP_SSIGN = 2;
    // Second duration of a pair, channel config fields and the status channel field
    localparam int T_HI = 16;
    localparam int CFG_DIFF = 0;
    localparam int CFG_SEL = 4;
    localparam int STS_CH = 4;
    // Minus input choices and the reset acquisition duration
    localparam logic [2:0] NEG_GND = 3'h0;
    localparam logic [2:0] NEG_REF = 3'h1;
    localparam logic [2:0] NEG_P1 = 3'h2;
    localparam logic [2:0] NEG_P7 = 3'h5;
    localparam logic [9:0] ACQ_RST = 10'h004;
    // ==========================================
    // Types
    // ==========================================
    typedef struct packed {
        logic diff;
        logic [1:0] acq_sel;
    } sac_chan_cfg_t;
    typedef struct packed {
        logic left;
        logic signed_fmt;
        logic gnd_clip;
    } sac_fmt_t;
    typedef enum {ST_IDLE, ST_ACQ, ST_CONV, ST_EOC, ST_AZ} sac_state_t;
endpackage

// File: sac_result_store.sv
// Result formatter and the sixteen per-channel result registers.
// Assumes wr is a one-cycle pulse on pclk carrying a final code.
`timescale 1ns/1ns
module sac_result_store (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic wr,
    input wire logic [3:0] wr_chan,
    input wire logic [sac_pkg::CODE_W-1:0] wr_code,
    input wire sac_pkg::sac_fmt_t fmt,
    input wire logic [3:0] rd_chan,
    output logic [sac_pkg::RES_W-1:0] rd_data,
    output logic [sac_pkg::RES_W-1:0] last_data
);
    import sac_pkg::*;
    // ==========================================
    // Formatting
    // ==========================================
    logic [CODE_W-1:0] code;
    logic [RES_W-1:0] fmt_word;
    logic [RES_W-1:0] res [NCH];
    logic [RES_W-1:0] next_last;
    // Offset binary in, sign flip for two's complement, clip for ground-referenced inputs
    always_comb begin
        code = wr_code;
        if (fmt.gnd_clip) begin
            code = wr_code[CODE_W-1] ? {1'b0, wr_code[CODE_W-2:0]} : '0;
        end else if (fmt.signed_fmt) begin
            code = wr_code ^ CODE_MID;
        end
        if (fmt.left) begin
            fmt_word = {code, 4'h0};
        end else if (fmt.signed_fmt && !fmt.gnd_clip) begin
            fmt_word = {{(RES_W-CODE_W){code[CODE_W-1]}}, code};
        end else begin
            fmt_word = {{(RES_W-CODE_W){1'b0}}, code};
        end
        next_last = wr ? fmt_word : last_data;
    end
    // ==========================================
    // Storage, one word per channel
    // ==========================================
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_res
            logic [RES_W-1:0] next_res;
            always_comb begin
                next_res = (wr && wr_chan == 4'(g)) ? fmt_word : res[g];
            end
            // Held until this channel completes again
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    res[g] <= '0;
                end else begin
                    res[g] <= next_res;
                end
            end
        end
    endgenerate
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_data <= '0;
        end else begin
            last_data <= next_last;
        end
    end
    assign rd_data = res[rd_chan];
    // ==========================================
    // Checks
    // ==========================================
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_left_low_zero: assert property (wr && fmt.left |=> last_data[3:0] == 4'h0)
        else $error("left aligned result has nonzero low bits");
    a_sign_fill: assert property (wr && !fmt.left && fmt.signed_fmt && !fmt.gnd_clip
        |=> last_data[15:12] == {4{last_data[11]}})
        else $error("signed result not sign extended");
    a_unsigned_fill: assert property (wr && !fmt.left && !fmt.signed_fmt && !fmt.gnd_clip
        |=> last_data == {4'h0, $past(wr_code)})
        else $error("unsigned right aligned result wrong");
    a_gnd_clip_span: assert property (wr && fmt.gnd_clip && !fmt.left |=> last_data <= 16'h07ff)
        else $error("ground referenced result above 11-bit span");
    a_mid_code: assert property (wr && !fmt.gnd_clip && !fmt.left && wr_code == CODE_MID
        |=> last_data == (fmt.signed_fmt ? 16'h0000 : 16'h0800))
        else $error("midpoint coding wrong");
    a_result_hold: assert property (!(wr && wr_chan == rd_chan)
        |=> res[$past(rd_chan)] == $past(res[rd_chan]))
        else $error("result changed without a completion");
    c_left_signed: cover property (wr && fmt.left && fmt.signed_fmt);
endmodule // sac_result_store

// File: sac_conv_ctrl.sv
// Control and result path of a 12-bit successive-approximation converter.
// Assumes an APB master on pclk, a sequencer and an analog core on pclk.
//
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/1ns
module sac_conv_ctrl (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic seq_req,
    input wire logic [3:0] seq_chan,
    output logic seq_ready,
    output logic [3:0] mux_chan,
    output logic mux_diff,
    output logic [2:0] mux_minus_input_select,
    output logic sample_en,
    output logic conv_tick,
    output logic [sac_pkg::CODE_W-1:0] sar_trial,
    input wire logic core_cmp,
    output logic eoc,
    output logic [3:0] eoc_chan,
    output logic [sac_pkg::RES_W-1:0] eoc_data
);
    import sac_pkg::*;
    // ==========================================
    // Register file
    // ==========================================
    logic [31:0] converter_global_control, next_ctrl;
    logic [2:0] sample_control_reg, next_smp;
    logic [ACQ_W-1:0] acq_dur [4];
    logic [ACQ_W-1:0] next_dur [4];
    sac_chan_cfg_t channel_config_reg [NCH];
    sac_chan_cfg_t next_cfg [NCH];
    logic [31:0] next_prdata;
    logic next_err, wr_acc, in_cfg, in_res, hit, fw_start;
    logic [3:0] widx;
    logic [RES_W-1:0] rd_res;
    sac_state_t state_q, next_state;
    assign widx = paddr[5:2];
    assign in_cfg = (paddr & OFS_WIN_MASK) == OFS_CFG_BASE;
    assign in_res = (paddr & OFS_WIN_MASK) == OFS_RES_BASE;
    assign wr_acc = psel && penable && pwrite;
    assign fw_start = wr_acc && paddr == OFS_CTRL && pwdata[CTRL_START];
    // Writes take effect in the access cycle; start is a self-clearing strobe
    always_comb begin
        next_ctrl = converter_global_control;
        next_smp = sample_control_reg;
        next_dur = acq_dur;
        next_cfg = channel_config_reg;
        if (wr_acc) begin
            if (paddr == OFS_CTRL) begin
                next_ctrl = pwdata & 32'h0000_0f77; // Start bit never stored
            end
            if (paddr == OFS_SAMPLE) begin
                next_smp = pwdata[2:0];
            end
            if (paddr == OFS_TLOW) begin
                next_dur[0] = pwdata[ACQ_W-1:0];
                next_dur[1] = pwdata[T_HI +: ACQ_W];
            end
            if (paddr == OFS_THIGH) begin
                next_dur[2] = pwdata[ACQ_W-1:0];
                next_dur[3] = pwdata[T_HI +: ACQ_W];
            end
            if (in_cfg) begin
                next_cfg[widx] = '{diff: pwdata[CFG_DIFF], acq_sel: pwdata[CFG_SEL +: 2]};
            end
        end
    end
    // Read data is fetched in the setup cycle so that the access cycle drives a flop
    always_comb begin
        hit = 1'b1;
        next_prdata = '0;
        unique case (1'b1)
            paddr == OFS_CTRL: next_prdata = converter_global_control;
            paddr == OFS_SAMPLE: next_prdata = {29'h0, sample_control_reg};
            paddr == OFS_TLOW: next_prdata = {6'h0, acq_dur[1], 6'h0, acq_dur[0]};
            paddr == OFS_THIGH: next_prdata = {6'h0, acq_dur[3], 6'h0, acq_dur[2]};
            paddr == OFS_STATUS: next_prdata = {24'h0, mux_chan, 3'h0, state_q != ST_IDLE};
            in_cfg: next_prdata = {26'h0, channel_config_reg[widx].acq_sel, 3'h0,
                channel_config_reg[widx].diff};
            in_res: next_prdata = {16'h0, rd_res};
            default: hit = 1'b0;
        endcase
        next_err = !hit || (pwrite && (paddr == OFS_STATUS || in_res));
        if (!(psel && !penable)) begin
            next_prdata = prdata;
            next_err = pslverr;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            converter_global_control <= '0;
            sample_control_reg <= '0;
            acq_dur <= '{ACQ_RST, ACQ_RST, ACQ_RST, ACQ_RST};
            channel_config_reg <= '{default: '0};
            prdata <= '0;
            pslverr <= 1'b0;
        end else begin
            converter_global_control <= next_ctrl;
            sample_control_reg <= next_smp;
            acq_dur <= next_dur;
            channel_config_reg <= next_cfg;
            prdata <= next_prdata;
            pslverr <= next_err && !penable;
        end
    end
    assign pready = 1'b1;
    // ==========================================
    // Conversion sequence
    // ==========================================
    logic [2:0] div_q, next_div;
    logic [ACQ_W-1:0] cnt_q, next_cnt, acq_len_q, next_acq_len, sel_dur;
    logic [3:0] bit_q, next_bit, chan_q, next_chan, req_chan;
    logic [CODE_W-1:0] sar_q, next_sar;
    sac_chan_cfg_t cur_q, next_cur;
    logic en, cont, fw_mode, start_req, tick, wr_res;
    sac_fmt_t fmt;
    assign en = converter_global_control[CTRL_EN];
    assign cont = converter_global_control[CTRL_CONT];
    assign fw_mode = converter_global_control[CTRL_FW];
    // Firmware writes or the sequencer steer the selector, never both
    assign req_chan = fw_mode ? converter_global_control[CTRL_FWCH +: 4] : seq_chan;
    assign start_req = en && (fw_mode ? fw_start : seq_req);
    assign tick = (state_q != ST_IDLE) && div_q == DIV_LAST;
    assign wr_res = state_q == ST_CONV && tick && bit_q == 4'h0;
    // Durations below the floor would starve the hold capacitor, so they count as four
    always_comb begin
        sel_dur = acq_dur[channel_config_reg[next_chan].acq_sel];
        next_acq_len = acq_len_q;
        if (next_state == ST_ACQ && state_q != ST_ACQ) begin
            next_acq_len = (sel_dur < ACQ_MIN) ? ACQ_MIN : sel_dur;
        end
    end
    // One step per converter clock: acquire, twelve decisions, end flag, auto-zero
    always_comb begin
        next_state = state_q;
        next_div = (state_q == ST_IDLE || tick) ? 3'h0 : div_q + 3'h1;
        next_cnt = cnt_q;
        next_bit = bit_q;
        next_sar = sar_q;
        next_chan = chan_q;
        next_cur = cur_q;
        unique case (state_q)
            ST_IDLE: begin
                if (start_req) begin
                    next_state = ST_ACQ;
                    next_chan = req_chan;
                    next_cnt = '0;
                end
            end
            ST_ACQ: begin
                if (tick) begin
                    next_cnt = cnt_q + 10'h001;
                    if (cnt_q == acq_len_q - 10'h001) begin
                        next_state = ST_CONV;
                        next_bit = TOP_BIT;
                        next_sar = CODE_MID;
                    end
                end
            end
            ST_CONV: begin
                if (tick) begin
                    next_sar[bit_q] = core_cmp;
                    if (bit_q == 4'h0) begin
                        next_state = ST_EOC;
                    end else begin
                        next_bit = bit_q - 4'h1;
                        next_sar[bit_q - 4'h1] = 1'b1;
                    end
                end
            end
            ST_EOC: begin
                if (tick) begin
                    next_state = ST_AZ;
                end
            end
            ST_AZ: begin
                if (tick) begin
                    next_state = cont ? ST_ACQ : ST_IDLE;
                    next_cnt = '0;
                end
            end
        endcase
        if (next_state == ST_ACQ && state_q != ST_ACQ) begin
            next_cur = channel_config_reg[next_chan];
        end
        if (!en) begin
            next_state = ST_IDLE;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
            div_q <= '0;
            cnt_q <= '0;
            acq_len_q <= ACQ_MIN;
            bit_q <= '0;
            sar_q <= '0;
            chan_q <= '0;
            cur_q <= '0;
        end else begin
            state_q <= next_state;
            div_q <= next_div;
            cnt_q <= next_cnt;
            acq_len_q <= next_acq_len;
            bit_q <= next_bit;
            sar_q <= next_sar;
            chan_q <= next_chan;
            cur_q <= next_cur;
        end
    end
    // Ground-referenced single-ended input cannot go negative, so sign is moot
    always_comb begin
        fmt.left = sample_control_reg[SMP_LEFT];
        fmt.gnd_clip = !cur_q.diff && mux_minus_input_select == NEG_GND;
        fmt.signed_fmt = cur_q.diff ? sample_control_reg[SMP_DSIGN] : sample_control_reg[SMP_SSIGN];
    end
    sac_result_store u_store (
        .pclk(pclk),
        .presetn(presetn),
        .wr(wr_res),
        .wr_chan(chan_q),
        .wr_code({sar_q[CODE_W-1:1], core_cmp}),
        .fmt(fmt),
        .rd_chan(widx),
        .rd_data(rd_res),
        .last_data(eoc_data)
    );
    // ==========================================
    // Core and sequencer facing outputs
    // ==========================================
    assign mux_chan = chan_q;
    assign mux_diff = cur_q.diff;
    assign mux_minus_input_select = converter_global_control[CTRL_NEG +: 3];
    assign sample_en = state_q == ST_ACQ;
    assign conv_tick = tick;
    assign sar_trial = sar_q;
    assign eoc = state_q == ST_EOC;
    assign eoc_chan = chan_q;
    assign seq_ready = en && !fw_mode && state_q == ST_IDLE;
    // ==========================================
    // Checks
    // ==========================================
    logic [3:0] bits_seen;
    logic [ACQ_W-1:0] acq_seen;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bits_seen <= '0;
            acq_seen <= '0;
        end else begin
            bits_seen <= (state_q != ST_CONV) ? 4'h0 : bits_seen + 4'(tick);
            acq_seen <= (state_q != ST_ACQ) ? '0 : acq_seen + 10'(tick);
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_eoc_one_clock: assert property ($rose(eoc) |-> eoc[*7] ##1 !eoc)
        else $error("end of conversion not one converter clock");
    a_result_with_eoc: assert property (wr_res |=> $rose(eoc) && eoc_chan == $past(chan_q))
        else $error("result not written with end of conversion");
    a_twelve_bits: assert property ($rose(eoc) |-> $past(bits_seen) == 4'hb && $past(tick))
        else $error("conversion did not take twelve decisions");
    a_acq_length: assert property ($fell(sample_en) && en |-> $past(acq_seen) == acq_len_q - 10'h001)
        else $error("acquisition length differs from selection");
    a_acq_floor: assert property (sample_en |-> acq_len_q >= ACQ_MIN)
        else $error("acquisition below four clocks");
    a_release_hold: assert property ($rose(state_q == ST_CONV) |-> $past(sample_en) && sar_trial == CODE_MID)
        else $error("conversion started without ending acquisition");
    a_diff_applied: assert property ($rose(sample_en) |-> mux_diff == channel_config_reg[mux_chan].diff)
        else $error("channel mode not applied");
    a_fw_route: assert property ($rose(sample_en) && fw_mode && $past(state_q) == ST_IDLE
        |-> mux_chan == converter_global_control[CTRL_FWCH +: 4])
        else $error("firmware channel not routed");
    a_az_cycle: assert property ($fell(eoc) && en |-> state_q == ST_AZ [*7])
        else $error("auto-zero clock missing");
    c_diff_conv: cover property (wr_res && cur_q.diff);
    c_fw_conv: cover property (wr_res && fw_mode);
    c_cont_restart: cover property (state_q == ST_AZ && next_state == ST_ACQ);
    c_gnd_clip: cover property (wr_res && fmt.gnd_clip);
endmodule // sac_conv_ctrl

// File: sac_far_model.sv
// Far side of the converter: channel sequencer and analog core comparator.
// Assumes the controller runs on pclk and the core compares on the same clock.
`timescale 1ns/1ns
module sac_far_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic go,
    input wire logic [3:0] chan,
    input wire logic [11:0] vin,
    input wire logic seq_ready,
    input wire logic sample_en,
    input wire logic [11:0] sar_trial,
    output logic seq_req,
    output logic [3:0] seq_chan,
    output logic core_cmp
);
    logic [11:0] held;
    // ==========================================
    // Sequencer: one start per ready window, never held over a busy period
    // ==========================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq_req <= 1'b0;
            seq_chan <= 4'h0;
        end else begin
            seq_req <= go && seq_ready && !seq_req;
            seq_chan <= chan;
        end
    end
    // Hold capacitor tracks the input only while sampling, then stays put
    always_ff @(posedge pclk) begin
        if (sample_en) begin
            held <= vin;
        end
    end
    // Comparator keeps a trial bit while the held input is at or above it
    assign core_cmp = (sar_trial <= held);
endmodule // sac_far_model

// File: sar_adc_core_result_timing_tb_top.sv
// Self-checking bench: APB tasks, firmware and sequencer conversions.
// Assumes a converter tick of seven pclk cycles; APB waits follow pready.
`timescale 1ns/1ns
module sar_adc_core_result_timing_tb_top;
    import sac_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0;
    logic [11:0] paddr = 12'h000, vin = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] chan = 4'h0, seq_chan, mux_chan, eoc_chan;
    logic pready, pslverr, seq_req, seq_ready, mux_diff, sample_en, conv_tick, core_cmp, eoc, er;
    logic [2:0] mux_minus_input_select;
    logic [11:0] sar_trial;
    logic [15:0] eoc_data;
    logic [15:0] exp_res [16];
    int failures = 0, compares = 0, cycles = 0, gap = 0;
    sac_conv_ctrl u_sac_conv_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .seq_req(seq_req), .seq_chan(seq_chan), .seq_ready(seq_ready),
        .mux_chan(mux_chan), .mux_diff(mux_diff), .mux_minus_input_select(mux_minus_input_select), .sample_en(sample_en),
        .conv_tick(conv_tick), .sar_trial(sar_trial), .core_cmp(core_cmp), .eoc(eoc),
        .eoc_chan(eoc_chan), .eoc_data(eoc_data));
    sac_far_model u_sac_far_model (.pclk(pclk), .presetn(presetn), .go(go), .chan(chan), .vin(vin),
        .seq_ready(seq_ready), .sample_en(sample_en), .sar_trial(sar_trial), .seq_req(seq_req),
        .seq_chan(seq_chan), .core_cmp(core_cmp));
    // ==========================================
    // Clock, timeout and checking helpers
    // ==========================================
    initial begin
        forever #4 pclk = ~pclk;
    end
    // Ceiling covers the long 1023-tick case with ample margin
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 40000) begin
            failures++;
            close_out();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
        compares++;
        if (seen !== expv) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, expv);
        end
    endtask
    task automatic close_out();
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // One APB transfer; holds the request until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Expected result word: ground clip, offset flip for signed, then alignment
    function automatic logic [15:0] fexp(logic [11:0] c, logic d, logic [2:0] n, logic [2:0] s);
        logic [11:0] k;
        logic sg;
        logic [15:0] r;
        k = c;
        sg = d ? s[SMP_DSIGN] : s[SMP_SSIGN];
        if (!d && n == NEG_GND) begin
            k = (c < CODE_MID) ? 12'h000 : c - CODE_MID;
            sg = 1'b0;
        end else if (sg) k = c ^ CODE_MID;
        r = sg ? {{4{k[11]}}, k} : {4'h0, k};
        if (s[SMP_LEFT]) r = {k, 4'h0};
        return r;
    endfunction
    // One conversion from setup to result read-back, timed at the ports
    task automatic conv(input logic [3:0] ch, input logic d, input logic [1:0] sel, input logic [2:0] n,
        input logic [2:0] s, input logic [11:0] v, input logic sq, input int acq);
        int na, nt, ne, n0;
        na = 0;
        nt = 0;
        ne = 0;
        n0 = 0;
        vin <= v;
        chan <= ch;
        apb(1'b1, OFS_SAMPLE, {29'h0, s});
        apb(1'b1, OFS_CFG_BASE + {6'h0, ch, 2'h0}, {26'h0, sel, 3'h0, d});
        apb(1'b1, OFS_CTRL, {20'h0, ch, 1'b0, n, 1'b0, ~sq, 1'b0, 1'b1});
        if (sq) go <= 1'b1;
        else apb(1'b1, OFS_CTRL, {20'h0, ch, 1'b0, n, 4'hd});
        while (eoc !== 1'b1 && nt < 20000) begin
            @(posedge pclk);
            if (sample_en === 1'b1 && na == 0) begin
                chk(mux_chan, ch);
                chk(mux_diff, d);
                chk(mux_minus_input_select, n);
            end
            if (sample_en === 1'b1) na++;
            if (na > 0 && eoc !== 1'b1) nt++;
            if (na > 0 && eoc !== 1'b1 && conv_tick === 1'b1) n0++;
        end
        go <= 1'b0;
        chk(na, 7 * acq);
        chk(nt, 7 * (acq + 12));
        chk(n0, acq + 12);
        chk(eoc_data, fexp(v, d, n, s));
        chk(eoc_chan, ch);
        while (eoc === 1'b1 && ne < 20) begin
            @(posedge pclk);
            ne++;
        end
        chk(ne, 7);
        exp_res[ch] = fexp(v, d, n, s);
        repeat (16) @(posedge pclk);
        apb(1'b0, OFS_RES_BASE + {6'h0, ch, 2'h0}, 32'h0);
        chk(rd, {16'h0, exp_res[ch]});
        $display("test conv ch=%0d done", ch);
    endtask
    // ==========================================
    // Main sequence
    // ==========================================
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OFS_TLOW, 32'h0);
        chk(rd, 32'h00040004);
        apb(1'b0, OFS_THIGH, 32'h0);
        chk(rd, 32'h00040004);
        apb(1'b0, 12'h020, 32'h0);
        chk(er, 1'b1);
        apb(1'b1, OFS_STATUS, 32'h1);
        chk(er, 1'b1);
        $display("test reset and map done");
        apb(1'b1, OFS_TLOW, 32'h00050004);
        apb(1'b1, OFS_THIGH, 32'h03ff0002);
        conv(4'h0, 1'b1, 2'h0, NEG_REF, 3'h0, 12'hfff, 1'b0, 4);
        conv(4'h1, 1'b1, 2'h1, NEG_REF, 3'h2, 12'h123, 1'b0, 5);
        conv(4'h2, 1'b0, 2'h0, NEG_GND, 3'h5, 12'ha5c, 1'b0, 4); // Temperature input stays single-ended
        conv(4'h3, 1'b0, 2'h2, NEG_REF, 3'h4, 12'h400, 1'b0, 4);
        conv(4'h4, 1'b0, 2'h3, NEG_P7, 3'h3, 12'h001, 1'b0, 1023);
        conv(4'hf, 1'b1, 2'h0, NEG_P1, 3'h3, 12'h7ff, 1'b1, 4);
        apb(1'b0, OFS_RES_BASE + 12'h004, 32'h0);
        chk(rd, {16'h0, exp_res[1]});
        $display("test hold done");
        // Continuous mode restarts after auto-zero; clearing enable aborts with no result
        vin <= 12'h5a5;
        apb(1'b1, OFS_CFG_BASE + 12'h014, 32'h0000_0001);
        apb(1'b1, OFS_CTRL, 32'h0000_0517);
        apb(1'b1, OFS_CTRL, 32'h0000_051f);
        while (eoc !== 1'b1) begin
            @(posedge pclk);
        end
        while (eoc === 1'b1) begin
            @(posedge pclk);
        end
        while (eoc !== 1'b1) begin
            @(posedge pclk);
            gap++;
        end
        chk(gap, 7 * (18 - 1));
        chk(eoc_data, fexp(12'h5a5, 1'b1, NEG_REF, 3'h3));
        vin <= 12'h0f0;
        repeat (60) @(posedge pclk);
        apb(1'b1, OFS_CTRL, 32'h0);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(rd, 32'h0000_0050);
        apb(1'b0, OFS_RES_BASE + 12'h014, 32'h0);
        chk(rd, {16'h0, fexp(12'h5a5, 1'b1, NEG_REF, 3'h3)});
        $display("test continuous done");
        close_out();
    end
endmodule // sar_adc_core_result_timing_tb_top
